// [rtl/adcss_pkg.sv]
// Purpose: constants for the summation/shift accumulator beside the ADC
// Assumes: byte-wide special function register access on one clock
// Notes: offsets are register addresses on the 8-bit register bus
package adcss_pkg;
  // register addresses
  localparam logic [7:0] ADDR_DECIM_LOW = 8'hDE;
  localparam logic [7:0] ADDR_DECIM_HIGH = 8'hDF;
  localparam logic [7:0] ADDR_CONTROL = 8'hE1;
  localparam logic [7:0] ADDR_TOTAL0 = 8'hE2;
  localparam logic [7:0] ADDR_TOTAL1 = 8'hE3;
  localparam logic [7:0] ADDR_TOTAL2 = 8'hE4;
  localparam logic [7:0] ADDR_TOTAL3 = 8'hE5;
  // reset values
  localparam logic [7:0] RST_DECIM_LOW = 8'h1B;
  localparam logic [2:0] RST_DECIM_HIGH = 3'h6;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_TOTAL_BYTE = 8'h00;
  // field layout
  localparam int DECIM_HIGH_W = 3;
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam int COUNT_MSB = 5;
  localparam int COUNT_LSB = 3;
  localparam int SHIFT_MSB = 2;
  localparam int SHIFT_LSB = 0;
  // mode codes
  localparam logic [1:0] MODE_CPU_ADD = 2'h0;
  localparam logic [1:0] MODE_ADC_SUM = 2'h1;
  localparam logic [1:0] MODE_CPU_SHIFT = 2'h2;
  localparam logic [1:0] MODE_ADC_SUM_SHIFT = 2'h3;
  // polarity
  localparam logic POL_BIPOLAR = 1'b0;
  // timing
  localparam int SHIFT_CYCLES = 4;
  localparam int MOD_OVERSAMPLE = 64;
  localparam int MOD_OVERSAMPLE_LOG2 = $clog2(MOD_OVERSAMPLE);
endpackage

// [rtl/adcss_rate_gen.sv]
// Purpose: conversion-rate tick from modulator divider and decimation ratio
// Assumes: settings are static while conversions run
// Notes: a ratio of zero is served as one
`timescale 1ns/100ps
module adcss_rate_gen #(
  parameter int DIV_W = 5,
  parameter int RATIO_W = 11
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // settings
  input wire logic [DIV_W-1:0] modClkDivider,
  input wire logic [RATIO_W-1:0] decimRatio,
  // tick
  output logic conversionTick
);
  import adcss_pkg::*;
  localparam int CNT_W = DIV_W + 1 + RATIO_W + MOD_OVERSAMPLE_LOG2;

  initial begin
    if (DIV_W < 1 || RATIO_W < 1 || CNT_W > 31) begin
      $error("adcss_rate_gen: unsupported width");
    end
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } adcss_rate_state_t;

  adcss_rate_state_t s;
  adcss_rate_state_t next_s;
  logic [RATIO_W-1:0] ratioEff;
  logic [CNT_W-1:0] limit;

  always_comb begin
    next_s = s;
    ratioEff = (decimRatio == '0) ? RATIO_W'(1) : decimRatio;
    // (divider + 1) * 64 * ratio system clocks per result
    limit = (CNT_W'({1'b0, modClkDivider}) + CNT_W'(1)) * CNT_W'(ratioEff)
      << MOD_OVERSAMPLE_LOG2;
    next_s.tick = 1'b0;
    if (s.cnt >= limit - CNT_W'(1)) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign conversionTick = s.tick;
endmodule // adcss_rate_gen

// [rtl/adcss_summation_shifter.sv]
// Purpose: 32-bit summation and shift accumulator with decimation setting
// Assumes: register strobes and ADC result come from logic on clk_sys
// Notes: read data is registered, valid the cycle after the read strobe
`timescale 1ns/100ps
module adcss_summation_shifter #(
  parameter int TOTAL_W = 32,
  parameter int RESULT_W = 24,
  parameter int DIV_W = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register bus
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // converter side
  input wire logic [RESULT_W-1:0] adcResult,
  input wire logic adcResultValid,
  input wire logic adcPowerDown,
  input wire logic resultSignMode,
  input wire logic [DIV_W-1:0] modClkDivider,
  // decimation and rate
  output logic [10:0] decimRatio,
  output logic conversionTick,
  // status and interrupt
  input wire logic sumIrqEnable,
  output logic shiftBusy,
  output logic sumDoneFlag,
  output logic sumDoneIrq
);
  import adcss_pkg::*;

  initial begin
    if (TOTAL_W != 32) begin
      $error("adcss_summation_shifter: total must be four bytes");
    end
    if (RESULT_W < 1 || RESULT_W >= TOTAL_W) begin
      $error("adcss_summation_shifter: unsupported result width");
    end
    if (SHIFT_CYCLES < 1 || SHIFT_CYCLES > 4) begin
      $error("adcss_summation_shifter: shift cycles exceed counter");
    end
    if (DIV_W < 1 || DIV_W > 8) begin
      $error("adcss_summation_shifter: unsupported divider width");
    end
  end

  // shift phase ignores new samples until the total is shifted
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SHIFT
  } adcss_phase_t;

  // all state of the block except the rateGen counter in one registered struct
  typedef struct packed {
    logic [7:0] decimLow;
    logic [DECIM_HIGH_W-1:0] decimHigh;
    logic [7:0] control;
    logic [TOTAL_W-1:0] total;
    logic [TOTAL_W-9:0] pending;
    logic [8:0] count;
    logic doneFlag;
    logic [1:0] shiftCycle;
    logic shiftSetsFlag;
    adcss_phase_t phase;
    logic [7:0] rdata;
  } adcss_state_t;

  adcss_state_t s;
  adcss_state_t next_s;

  // decoded control fields and datapath helpers
  logic [1:0] accumulateMode;
  logic [2:0] accumulateCountSelect;
  logic [2:0] shiftAmountSelect;
  logic [3:0] shiftBits;
  logic [8:0] countTarget;
  logic bipolar;
  logic signBit;
  logic [TOTAL_W-1:0] resultExtended;
  logic [TOTAL_W-1:0] shiftedTotal;
  logic [7:0] readValue;
  logic adcMode;
  logic sampleTaken;
  logic countDone;

  // control fields
  always_comb begin
    accumulateMode = s.control[MODE_MSB:MODE_LSB];
    accumulateCountSelect = s.control[COUNT_MSB:COUNT_LSB];
    shiftAmountSelect = s.control[SHIFT_MSB:SHIFT_LSB];
    shiftBits = {1'b0, shiftAmountSelect} + 4'h1;
    countTarget = 9'h001 << ({1'b0, accumulateCountSelect} + 4'h1);
    bipolar = (resultSignMode == POL_BIPOLAR);
    adcMode = (accumulateMode == MODE_ADC_SUM) ||
      (accumulateMode == MODE_ADC_SUM_SHIFT);
  end

  // result extension and shifter
  always_comb begin
    signBit = bipolar & adcResult[RESULT_W-1];
    resultExtended = {{(TOTAL_W-RESULT_W){signBit}}, adcResult};
    if (bipolar) begin
      shiftedTotal = TOTAL_W'($signed(s.total) >>> shiftBits);
    end else begin
      shiftedTotal = s.total >> shiftBits;
    end
  end

  // register read mux, unmapped addresses read zero
  always_comb begin
    case (sfrAddr)
      ADDR_DECIM_LOW: begin
        readValue = s.decimLow;
      end
      ADDR_DECIM_HIGH: begin
        readValue = {{(8-DECIM_HIGH_W){1'b0}}, s.decimHigh};
      end
      ADDR_CONTROL: begin
        readValue = s.control;
      end
      ADDR_TOTAL0: begin
        readValue = s.total[7:0];
      end
      ADDR_TOTAL1: begin
        readValue = s.total[15:8];
      end
      ADDR_TOTAL2: begin
        readValue = s.total[23:16];
      end
      ADDR_TOTAL3: begin
        readValue = s.total[31:24];
      end
      default: begin
        readValue = 8'h00;
      end
    endcase
  end

  always_comb begin
    next_s = s;
    sampleTaken = 1'b0;
    countDone = 1'b0;

    // reads: registered data and flag clear
    // the clear comes before every set below, so a same-cycle set wins
    if (sfrRead) begin
      next_s.rdata = readValue;
      if (sfrAddr == ADDR_TOTAL0) begin
        next_s.doneFlag = 1'b0;
      end
    end

    // writes
    if (sfrWrite) begin
      case (sfrAddr)
        ADDR_DECIM_LOW: begin
          next_s.decimLow = sfrWdata;
        end
        ADDR_DECIM_HIGH: begin
          next_s.decimHigh = sfrWdata[DECIM_HIGH_W-1:0];
        end
        ADDR_CONTROL: begin
          next_s.control = sfrWdata;
          // mode 10 starts a shift, other non-zero writes restart the count
          if (sfrWdata == 8'h00) begin
            next_s.total = '0;
            next_s.pending = '0;
            next_s.count = '0;
            next_s.phase = ST_IDLE;
          end else if (sfrWdata[MODE_MSB:MODE_LSB] == MODE_CPU_SHIFT) begin
            next_s.phase = ST_SHIFT;
            next_s.shiftCycle = 2'h0;
            next_s.shiftSetsFlag = 1'b0;
          end else begin
            next_s.count = '0;
          end
        end
        ADDR_TOTAL0: begin
          if (accumulateMode == MODE_CPU_ADD) begin
            // upper bytes staged earlier, added with the least byte
            next_s.total = s.total + {s.pending, sfrWdata};
          end else begin
            next_s.total[7:0] = sfrWdata;
          end
        end
        ADDR_TOTAL1: begin
          if (accumulateMode == MODE_CPU_ADD) begin
            next_s.pending[7:0] = sfrWdata;
          end else begin
            next_s.total[15:8] = sfrWdata;
          end
        end
        ADDR_TOTAL2: begin
          if (accumulateMode == MODE_CPU_ADD) begin
            next_s.pending[15:8] = sfrWdata;
          end else begin
            next_s.total[23:16] = sfrWdata;
          end
        end
        ADDR_TOTAL3: begin
          if (accumulateMode == MODE_CPU_ADD) begin
            next_s.pending[23:16] = sfrWdata;
          end else begin
            next_s.total[31:24] = sfrWdata;
          end
        end
        default: begin
        end
      endcase
    end

    // ADC accumulation, one add per valid result, merged with CPU writes
    case (s.phase)
      ST_IDLE: begin
        sampleTaken = adcMode && adcResultValid;
        if (sampleTaken) begin
          next_s.total = next_s.total + resultExtended;
          if (s.count + 9'h001 == countTarget) begin
            countDone = 1'b1;
            next_s.count = '0;
          end else begin
            next_s.count = s.count + 9'h001;
          end
        end
        if (countDone) begin
          if (accumulateMode == MODE_ADC_SUM_SHIFT) begin
            next_s.phase = ST_SHIFT;
            next_s.shiftCycle = 2'h0;
            next_s.shiftSetsFlag = 1'b1;
          end else begin
            next_s.doneFlag = 1'b1;
          end
        end
      end
      ST_SHIFT: begin
        // samples arriving during the four shift cycles are not added
        // a byte written in the last shift cycle is lost; earlier writes are shifted with the total
        if (s.shiftCycle == 2'(SHIFT_CYCLES - 1)) begin
          next_s.total = shiftedTotal;
          next_s.phase = ST_IDLE;
          if (s.shiftSetsFlag) begin
            next_s.doneFlag = 1'b1;
          end
        end else begin
          next_s.shiftCycle = s.shiftCycle + 2'h1;
        end
      end
      default: begin
        next_s.phase = ST_IDLE;
      end
    endcase

    // accumulator held in its cleared state while the ADC is off
    if (adcPowerDown) begin
      next_s.total = '0;
      next_s.pending = '0;
      next_s.count = '0;
      next_s.doneFlag = 1'b0;
      next_s.phase = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s.decimLow <= RST_DECIM_LOW;
      s.decimHigh <= RST_DECIM_HIGH;
      s.control <= RST_CONTROL;
      s.total <= {4{RST_TOTAL_BYTE}};
      s.pending <= '0;
      s.count <= '0;
      s.doneFlag <= 1'b0;
      s.shiftCycle <= 2'h0;
      s.shiftSetsFlag <= 1'b0;
      s.phase <= ST_IDLE;
      s.rdata <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  // ratio assembled from both registers
  assign decimRatio = {s.decimHigh, s.decimLow};

  adcss_rate_gen #(
    .DIV_W(DIV_W),
    .RATIO_W(11)
  ) rateGen (
    .clk_sys(clk_sys),
    .reset(reset),
    .modClkDivider(modClkDivider),
    .decimRatio(decimRatio),
    .conversionTick(conversionTick)
  );

  assign sfrRdata = s.rdata;
  assign shiftBusy = (s.phase == ST_SHIFT);
  assign sumDoneFlag = s.doneFlag;
  assign sumDoneIrq = s.doneFlag & sumIrqEnable;
endmodule // adcss_summation_shifter

// [test/adcss_properties.sv]
// Purpose: port assertions for the summation/shift accumulator
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the top module below
`timescale 1ns/100ps
module adcss_properties #(
  parameter int TOTAL_W = 32,
  parameter int RESULT_W = 24,
  parameter int DIV_W = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register bus
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  // converter side
  input wire logic [RESULT_W-1:0] adcResult,
  input wire logic adcResultValid,
  input wire logic adcPowerDown,
  input wire logic resultSignMode,
  input wire logic [DIV_W-1:0] modClkDivider,
  // decimation and rate
  input wire logic [10:0] decimRatio,
  input wire logic conversionTick,
  // status
  input wire logic sumIrqEnable,
  input wire logic shiftBusy,
  input wire logic sumDoneFlag,
  input wire logic sumDoneIrq
);
  import adcss_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  irq_mask_a: assert property (
    sumDoneIrq == (sumDoneFlag & sumIrqEnable)) else $error("irq mask");
  reset_ratio_a: assert property (
    $fell(reset) |-> decimRatio == 11'h61B) else $error("ratio reset");
  low_ratio_a: assert property (
    sfrWrite && sfrAddr == ADDR_DECIM_LOW
    |=> decimRatio[7:0] == $past(sfrWdata)) else $error("ratio low");
  high_ratio_a: assert property (
    sfrWrite && sfrAddr == ADDR_DECIM_HIGH
    |=> decimRatio[10:8] == $past(sfrWdata[2:0])) else $error("ratio high");
  shift_time_a: assert property (
    sfrWrite && sfrAddr == ADDR_CONTROL && sfrWdata[7:6] == MODE_CPU_SHIFT
    && !adcPowerDown |=> shiftBusy [*4] ##1 !shiftBusy)
    else $error("shift length");
  read_clear_a: assert property (
    sfrRead && sfrAddr == ADDR_TOTAL0 && !adcResultValid && !shiftBusy
    |=> !sumDoneFlag) else $error("flag not cleared");
  tick_gap_a: assert property (
    conversionTick |=> !conversionTick [*8]) else $error("tick spacing");
  pd_flag_a: assert property (
    adcPowerDown |=> !sumDoneFlag) else $error("flag in power down");
  pd_total_a: assert property (
    adcPowerDown [*2] ##0 (sfrRead && sfrAddr == ADDR_TOTAL3)
    |=> sfrRdata == 8'h00) else $error("total in power down");
  cover property (shiftBusy);
  cover property (sumDoneIrq);
  cover property (conversionTick);
endmodule // adcss_properties

bind adcss_summation_shifter adcss_properties #(.TOTAL_W(TOTAL_W),
  .RESULT_W(RESULT_W), .DIV_W(DIV_W)) props_u (.clk_sys(clk_sys),
  .reset(reset), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
  .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
  .adcResult(adcResult), .adcResultValid(adcResultValid),
  .adcPowerDown(adcPowerDown), .resultSignMode(resultSignMode),
  .modClkDivider(modClkDivider), .decimRatio(decimRatio),
  .conversionTick(conversionTick), .sumIrqEnable(sumIrqEnable),
  .shiftBusy(shiftBusy), .sumDoneFlag(sumDoneFlag),
  .sumDoneIrq(sumDoneIrq));

// [test/adcss_adc_model.sv]
// Purpose: converter result source for the accumulator bench
// Assumes: results handed over on clk_sys
// Notes: idle result lines show the inverse of the last result
`timescale 1ns/100ps
module adcss_adc_model (
  // clock
  input wire logic clk_sys,
  // request from bench
  input wire logic sendReq,
  input wire logic [23:0] sendData,
  // result path
  output logic [23:0] adcResult,
  output logic adcResultValid
);
  logic [23:0] lastData = 24'h000000;
  always @(posedge clk_sys) begin
    if (sendReq) begin
      lastData <= sendData;
    end
  end
  assign adcResultValid = sendReq;
  assign adcResult = sendReq ? sendData : ~lastData;
endmodule // adcss_adc_model

// [test/tb.sv]
// Purpose: self-checking bench for the summation/shift accumulator
// Assumes: inputs change 1 ns after the rising edge
// Notes: converter results come from the partner model
`timescale 1ns/100ps
module tb;
  import adcss_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrite = 1'b0;
  logic sfrRead = 1'b0;
  logic [7:0] sfrWdata = 8'h00;
  logic [7:0] sfrRdata;
  logic sendReq = 1'b0;
  logic [23:0] sendData = 24'h000000;
  logic [23:0] adcResult;
  logic adcResultValid;
  logic adcPowerDown = 1'b0;
  logic resultSignMode = 1'b0;
  logic [4:0] modClkDivider = 5'h00;
  logic sumIrqEnable = 1'b1;
  logic [10:0] decimRatio;
  logic conversionTick, shiftBusy, sumDoneFlag, sumDoneIrq;
  logic [31:0] v;
  int errors = 0;
  int tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  adcss_adc_model adc_u (.clk_sys(clk_sys), .sendReq(sendReq),
    .sendData(sendData), .adcResult(adcResult),
    .adcResultValid(adcResultValid));
  adcss_summation_shifter dut_u (.clk_sys(clk_sys), .reset(reset),
    .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .adcResult(adcResult),
    .adcResultValid(adcResultValid), .adcPowerDown(adcPowerDown),
    .resultSignMode(resultSignMode), .modClkDivider(modClkDivider),
    .decimRatio(decimRatio), .conversionTick(conversionTick),
    .sumIrqEnable(sumIrqEnable), .shiftBusy(shiftBusy),
    .sumDoneFlag(sumDoneFlag), .sumDoneIrq(sumDoneIrq));
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // each access leaves one idle cycle so no strobe is set twice at once
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    step(1);
    sfrWrite = 1'b0;
    step(1);
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    sfrAddr = a;
    sfrRead = 1'b1;
    step(1);
    sfrRead = 1'b0;
    d = sfrRdata;
    step(1);
  endtask
  task automatic send(logic [23:0] r);
    sendData = r;
    sendReq = 1'b1;
    step(1);
    sendReq = 1'b0;
    step(1);
  endtask
  task automatic rd_total(output logic [31:0] t);
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_TOTAL0 + 8'(i), t[8*i +: 8]);
    end
  endtask
  task automatic t_regs();
    logic [7:0] b;
    for (int a = 32'hDE; a <= 32'hE6; a++) begin
      rd(8'(a), b);
      chk("reset byte", 32'(b), a == 32'hDE ? 32'h1B :
        a == 32'hDF ? 32'h06 : 32'h00);
    end
    $display("test regs done");
  endtask
  task automatic t_rate();
    logic [7:0] b;
    int n = 0;
    modClkDivider = 5'h01;
    wr(ADDR_DECIM_LOW, 8'h01);
    wr(ADDR_DECIM_HIGH, 8'hF8);
    rd(ADDR_DECIM_HIGH, b);
    chk("ratio high", 32'(b), 32'h00);
    chk("ratio", 32'(decimRatio), 32'h001);
    while (conversionTick !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    n = 0;
    do begin
      step(1);
      n++;
    end while (conversionTick !== 1'b1 && n < 400);
    chk("tick period", 32'(n), 32'(2 * MOD_OVERSAMPLE));
    $display("test rate done");
  endtask
  task automatic t_cpu();
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CONTROL, 8'h01);
    repeat (2) begin
      wr(ADDR_TOTAL3, 8'h12);
      wr(ADDR_TOTAL2, 8'h34);
      wr(ADDR_TOTAL1, 8'h56);
      wr(ADDR_TOTAL0, 8'h78);
    end
    rd_total(v);
    chk("cpu sum", v, 32'h12345678 * 2);
    wr(ADDR_CONTROL, 8'h83);
    chk("busy", 32'(shiftBusy), 32'h1);
    step(4);
    rd_total(v);
    chk("shifted", v, (32'h12345678 * 2) >> 4);
    wr(ADDR_CONTROL, 8'h00);
    rd_total(v);
    chk("cleared", v, 32'h00000000);
    $display("test cpu done");
  endtask
  task automatic t_adc();
    wr(ADDR_CONTROL, 8'h40);
    send(24'hFFFFFE);
    chk("early flag", 32'(sumDoneFlag), 32'h0);
    send(24'hFFFFFE);
    chk("flag", 32'(sumDoneFlag), 32'h1);
    chk("irq", 32'(sumDoneIrq), 32'h1);
    sumIrqEnable = 1'b0;
    step(1);
    chk("masked", 32'(sumDoneIrq), 32'h0);
    sumIrqEnable = 1'b1;
    rd_total(v);
    chk("signed sum", v, 32'hFFFFFFFC);
    chk("flag read", 32'(sumDoneFlag), 32'h0);
    send(24'hFFFFFE);
    send(24'hFFFFFE);
    chk("flag again", 32'(sumDoneFlag), 32'h1);
    rd_total(v);
    chk("second sum", v, 32'hFFFFFFF8);
    $display("test adc done");
  endtask
  task automatic t_acc();
    resultSignMode = 1'b1;
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CONTROL, 8'hC9);
    repeat (4) send(24'h800000);
    send(24'h7FFFFF);
    step(6);
    chk("acc flag", 32'(sumDoneFlag), 32'h1);
    rd_total(v);
    chk("acc shift", v, (32'h00800000 * 4) >> 2);
    $display("test acc done");
  endtask
  task automatic t_pd();
    wr(ADDR_CONTROL, 8'h40);
    wr(ADDR_TOTAL3, 8'hA5);
    rd_total(v);
    chk("byte map", v, 32'hA5800000);
    repeat (2) send(24'h000001);
    chk("pre pd flag", 32'(sumDoneFlag), 32'h1);
    adcPowerDown = 1'b1;
    send(24'h000001);
    chk("pd flag", 32'(sumDoneFlag), 32'h0);
    rd_total(v);
    chk("pd total", v, 32'h00000000);
    adcPowerDown = 1'b0;
    $display("test power down done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    step(5);
    reset = 1'b0;
    t_regs();
    t_rate();
    t_cpu();
    t_adc();
    t_acc();
    t_pd();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    finish_test();
  end
endmodule // tb
